// file: lfp_pkg.sv
// Shared constants and types of the LED frame player
package lfp_pkg;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CHANNELS      = 16;
   localparam int UPPER         = 8;
   localparam int FRAME_BYTES   = 18;
   localparam int FRAME_COUNT   = 8;
   // Register offsets and the duty commit key
   localparam logic [7:0] A_CONFIG         = 8'h00;
   localparam logic [7:0] A_LED_HI         = 8'h01;
   localparam logic [7:0] A_LED_LO         = 8'h02;
   localparam logic [7:0] A_EFFECT         = 8'h03;
   localparam logic [7:0] A_CHAN_CFG       = 8'h04;
   localparam logic [7:0] A_GPIO_CFG       = 8'h05;
   localparam logic [7:0] A_GPIO_OUT       = 8'h06;
   localparam logic [7:0] A_IRQ_EN         = 8'h07;
   localparam logic [7:0] A_INPUT_SNAP     = 8'h08;
   localparam logic [7:0] A_SAMPLE_DIV     = 8'h09;
   localparam logic [7:0] A_DUTY_BASE      = 8'h10;
   localparam logic [7:0] A_DUTY_LAST      = 8'h1f;
   localparam logic [7:0] A_FRAME_BASE     = 8'h20;
   localparam logic [7:0] A_FRAME_LAST     = 8'haf;
   localparam logic [7:0] A_DUTY_COMMIT    = 8'hb0;
   localparam logic [7:0] A_FRAME_INTERVAL = 8'hb6;
   localparam logic [7:0] A_FIRST_FRAME    = 8'hb7;
   localparam logic [7:0] COMMIT_KEY       = 8'h00;
   // Reset values
   localparam logic [7:0] RST_CONFIG = 8'h80;
   localparam logic [7:0] RST_LED    = 8'hff;
   localparam logic [7:0] RST_ZERO   = 8'h00;
   // Field positions
   localparam int MODE_LSB = 5;
   localparam int CS_LSB   = 4;
   localparam int FDT_LSB  = 5;
   localparam int FS_LSB   = 5;
   localparam int LVL_LSB  = 5;
   // Timing
   localparam int FRAME_DLY0_NS   = 4870000;
   localparam int FRAME_DLY1_NS   = 9500000;
   localparam int SAMPLE_BASE_NS  = 10000;
   localparam int FRAME_DLY0_CYC  = FRAME_DLY0_NS / CLK_PERIOD_NS;
   localparam int FRAME_DLY1_CYC  = FRAME_DLY1_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_NS / CLK_PERIOD_NS;
   localparam int DLY_W           = 28;

   typedef enum logic [1:0] {
      MODE_PWM   = 2'b00,
      MODE_AUTO  = 2'b01,
      MODE_AUDIO = 2'b10,
      MODE_NA    = 2'b11
   } lfp_mode_t;

   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_ADDR = 3'b001,
      I_AACK = 3'b010,
      I_WR   = 3'b011,
      I_WACK = 3'b100,
      I_RD   = 3'b101,
      I_RACK = 3'b110
   } lfp_bus_st_t;
endpackage

// file: lfp_frame_if.sv
// Bundle of per-channel duty values and on/off mask
`timescale 1ns/100ps
interface lfp_frame_if;
   logic [7:0]  duty [lfp_pkg::CHANNELS];
   logic [15:0] on_mask;
   modport src (output duty, output on_mask);
   modport dst (input duty, input on_mask);
endinterface

// file: lfp_pwm_bank.sv
// Sixteen PWM comparators on one shared counter
`timescale 1ns/100ps
module lfp_pwm_bank (
   // Clock and reset
   input  wire logic                         i_clk,
   input  wire logic                         i_nrst,
   // Shown frame
   lfp_frame_if.dst                          shw,
   // Channel waveforms
   output logic [lfp_pkg::CHANNELS-1:0]      o_pwm
);
   import lfp_pkg::*;

   logic [7:0] cnt_r;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      always_ff @(posedge i_clk) begin
         if (!i_nrst) begin
            o_pwm[i] <= 1'b0;
         end else begin
            o_pwm[i] <= shw.on_mask[i] && (cnt_r < shw.duty[i]);
         end
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_shared_count;
      i_nrst |=> cnt_r == 8'($past(cnt_r) + 8'h01);
   endproperty
   a_shared_count: assert property (p_shared_count) else $error("PWM counter skipped");

   property p_duty_ratio;
      (shw.on_mask[0] && cnt_r < shw.duty[0]) |=> o_pwm[0];
   endproperty
   a_duty_ratio: assert property (p_duty_ratio) else $error("Channel off inside duty");

   property p_duty_off;
      (cnt_r >= shw.duty[0]) |=> !o_pwm[0];
   endproperty
   a_duty_off: assert property (p_duty_off) else $error("Channel on past duty");
endmodule

// file: lfp_frame_player.sv
// Eight-frame memory with auto-play and audio-driven selection
`timescale 1ns/100ps
module lfp_frame_player #(
   parameter int FRAME_DLY0_CYC = lfp_pkg::FRAME_DLY0_CYC,
   parameter int FRAME_DLY1_CYC = lfp_pkg::FRAME_DLY1_CYC
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_nrst,
   // Register write strobe
   input  wire logic              i_wr_en,
   input  wire logic [7:0]        i_wr_addr,
   input  wire logic [7:0]        i_wr_data,
   // Settings
   input  wire lfp_pkg::lfp_mode_t i_mode,
   input  wire logic [2:0]        i_delay_code,
   input  wire logic [2:0]        i_start_code,
   input  wire logic [7:0]        i_sample_div,
   input  wire logic [7:0]        i_level,
   // Selected frame contents
   lfp_frame_if.src               frm
);
   import lfp_pkg::*;

   if (FRAME_DLY0_CYC < 1 || FRAME_DLY1_CYC < 1 || FRAME_DLY1_CYC * 64 >= 2 ** DLY_W) begin : g_bad
      $error("Frame delay counts out of range");
   end

   logic [7:0]       mem [FRAME_BYTES*FRAME_COUNT];
   logic [2:0]       frame_r;
   lfp_mode_t        prev_r;
   logic [DLY_W-1:0] dly_r;
   logic [10:0]      tick_r;
   logic [7:0]       div_r;
   logic             enter_auto;
   logic             adv_evt;
   logic             base_tick;
   logic             smp_evt;

   function automatic logic [7:0] fidx(input logic [2:0] f, input int k);
      return 8'(int'(f) * FRAME_BYTES + k);
   endfunction

   function automatic logic [DLY_W-1:0] dly_target(input logic [2:0] c);
      if (c == 3'h0) return DLY_W'(FRAME_DLY0_CYC);
      return DLY_W'(FRAME_DLY1_CYC) << (c - 3'h1);
   endfunction

   always_ff @(posedge i_clk) begin
      if (i_wr_en && i_wr_addr >= A_FRAME_BASE && i_wr_addr <= A_FRAME_LAST) begin
         mem[i_wr_addr - A_FRAME_BASE] <= i_wr_data;
      end
   end

   // Stored frame drives the same fields as the live registers
   for (genvar k = 0; k < CHANNELS; k++) begin : g_duty
      assign frm.duty[k] = mem[fidx(frame_r, k + 2)];
   end
   assign frm.on_mask = {mem[fidx(frame_r, 0)], mem[fidx(frame_r, 1)]};

   assign enter_auto = i_mode == MODE_AUTO && prev_r != MODE_AUTO;
   assign adv_evt    = i_mode == MODE_AUTO && !enter_auto &&
                       dly_r >= dly_target(i_delay_code) - DLY_W'(1);
   assign base_tick  = tick_r == 11'(SAMPLE_BASE_CYC - 1);
   assign smp_evt    = i_mode == MODE_AUDIO && base_tick && i_sample_div != 8'h00 &&
                       div_r >= i_sample_div - 8'h01;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         frame_r <= 3'h0;
         prev_r  <= MODE_PWM;
      end else begin
         prev_r <= i_mode;
         if (enter_auto) begin
            frame_r <= i_start_code;
         end else if (adv_evt) begin
            frame_r <= frame_r + 3'h1;
         end else if (smp_evt) begin
            frame_r <= i_level[LVL_LSB +: 3];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_mode != MODE_AUTO || enter_auto || adv_evt) begin
         dly_r <= '0;
      end else begin
         dly_r <= dly_r + DLY_W'(1);
      end
   end

   // Sampling runs only in audio mode
   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_mode != MODE_AUDIO || base_tick) begin
         tick_r <= 11'h000;
      end else begin
         tick_r <= tick_r + 11'h001;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst || i_mode != MODE_AUDIO || smp_evt) begin
         div_r <= 8'h00;
      end else if (base_tick && i_sample_div != 8'h00) begin
         div_r <= div_r + 8'h01;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_start_frame;
      enter_auto |=> frame_r == $past(i_start_code);
   endproperty
   a_start_frame: assert property (p_start_frame) else $error("Wrong first frame");

   property p_wrap;
      adv_evt |=> frame_r == 3'($past(frame_r) + 3'h1);
   endproperty
   a_wrap: assert property (p_wrap) else $error("Frame did not advance");

   property p_interval;
      adv_evt |-> dly_r >= dly_target(i_delay_code) - DLY_W'(1) && !$past(adv_evt);
   endproperty
   a_interval: assert property (p_interval) else $error("Frame advanced early");

   property p_sample_period;
      smp_evt |-> tick_r == 11'(SAMPLE_BASE_CYC - 1) && div_r >= i_sample_div - 8'h01;
   endproperty
   a_sample_period: assert property (p_sample_period) else $error("Sample off tick");

   property p_audio_only;
      i_mode != MODE_AUDIO |-> !smp_evt;
   endproperty
   a_audio_only: assert property (p_audio_only) else $error("Sample outside audio");

   property p_halt;
      (i_mode == MODE_AUDIO && prev_r == MODE_AUDIO && i_sample_div == 8'h00) |=> $stable(frame_r);
   endproperty
   a_halt: assert property (p_halt) else $error("Frame moved with zero rate");

   property p_level_frame;
      smp_evt |=> frame_r == $past(i_level[7:5]);
   endproperty
   a_level_frame: assert property (p_level_frame) else $error("Audio frame mismatch");

   c_advance: cover property (adv_evt && frame_r == 3'h7);
   c_sample:  cover property (smp_evt);
endmodule

// file: lfp_top.sv
// LED driver core: serial register slave, duty latch, GPIO and interrupt
`timescale 1ns/100ps
module lfp_top #(
   parameter logic [6:0] DEV_ADDR       = 7'h3a, // Arbitrary bus address
   parameter int         FRAME_DLY0_CYC = lfp_pkg::FRAME_DLY0_CYC,
   parameter int         FRAME_DLY1_CYC = lfp_pkg::FRAME_DLY1_CYC
) (
   // Clock and reset
   input  wire logic                       i_clk,
   input  wire logic                       i_nrst,
   // Two-wire register bus
   input  wire logic                       i_scl,
   input  wire logic                       i_sda_in,
   output logic                            o_sda_out,
   output logic                            o_sda_oe,
   // Upper channel pins used as GPIO
   input  wire logic [lfp_pkg::UPPER-1:0]  i_gpio_in,
   output logic      [lfp_pkg::UPPER-1:0]  o_gpio_out,
   output logic      [lfp_pkg::UPPER-1:0]  o_gpio_oe,
   // Converter amplitude
   input  wire logic [7:0]                 i_audio_level,
   // LED drive
   output logic [lfp_pkg::CHANNELS-1:0]    o_led_pwm,
   output logic [2:0]                      o_cur_scale,
   output logic                            o_irq_n_pin
);
   import lfp_pkg::*;

   // Input synchronisers
   logic             scl_m, scl_s, scl_d;
   logic             sda_m, sda_s, sda_d;
   logic [UPPER-1:0] gin_m, gin_s, gin_d;
   logic [7:0]       lvl_m, lvl_s;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         {scl_m, scl_s, scl_d} <= 3'h7;
         {sda_m, sda_s, sda_d} <= 3'h7;
         {gin_m, gin_s, gin_d} <= '0;
         {lvl_m, lvl_s}        <= '0;
      end else begin
         {scl_m, scl_s, scl_d} <= {i_scl, scl_m, scl_s};
         {sda_m, sda_s, sda_d} <= {i_sda_in, sda_m, sda_s};
         {gin_m, gin_s, gin_d} <= {i_gpio_in, gin_m, gin_s};
         {lvl_m, lvl_s}        <= {i_audio_level, lvl_m};
      end
   end

   logic start_c, stop_c, rise_c, fall_c;
   assign start_c = scl_s && scl_d && sda_d && !sda_s;
   assign stop_c  = scl_s && scl_d && !sda_d && sda_s;
   assign rise_c  = scl_s && !scl_d;
   assign fall_c  = !scl_s && scl_d;

   // Bus slave
   lfp_bus_st_t st_r;
   logic [3:0]  bit_r;
   logic [7:0]  sh_r, tx_r, ptr_r;
   logic        first_r, rw_r, nack_r;
   logic        wr_en, rd_snap, load_tx;
   logic [7:0]  rd_val, snap_r;

   assign rd_val  = (ptr_r == A_INPUT_SNAP) ? snap_r : RST_ZERO;
   assign load_tx = fall_c && ((st_r == I_AACK && rw_r) || (st_r == I_RACK && !nack_r));
   assign rd_snap = load_tx && ptr_r == A_INPUT_SNAP;
   assign wr_en   = fall_c && st_r == I_WR && bit_r == 4'h8 && !first_r;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         st_r     <= I_IDLE;
         bit_r    <= 4'h0;
         sh_r     <= 8'h00;
         tx_r     <= 8'h00;
         ptr_r    <= 8'h00;
         first_r  <= 1'b0;
         rw_r     <= 1'b0;
         nack_r   <= 1'b0;
         o_sda_oe <= 1'b0;
      end else if (start_c) begin
         st_r     <= I_ADDR;
         bit_r    <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (stop_c) begin
         st_r     <= I_IDLE;
         o_sda_oe <= 1'b0;
      end else if (rise_c) begin
         case (st_r)
            I_ADDR, I_WR: begin
               sh_r  <= {sh_r[6:0], sda_s};
               bit_r <= bit_r + 4'h1;
            end
            I_RD:    bit_r  <= bit_r + 4'h1;
            I_RACK:  nack_r <= sda_s;
            default: ;
         endcase
      end else if (fall_c) begin
         case (st_r)
            I_ADDR: if (bit_r == 4'h8) begin
               bit_r <= 4'h0;
               if (sh_r[7:1] == DEV_ADDR) begin
                  st_r     <= I_AACK;
                  o_sda_oe <= 1'b1;
                  rw_r     <= sh_r[0];
               end else begin
                  st_r <= I_IDLE;
               end
            end
            I_AACK: begin
               first_r <= 1'b1;
               if (rw_r) begin
                  st_r     <= I_RD;
                  tx_r     <= rd_val;
                  o_sda_oe <= ~rd_val[7];
                  ptr_r    <= ptr_r + 8'h01;
               end else begin
                  st_r     <= I_WR;
                  o_sda_oe <= 1'b0;
               end
            end
            I_WR: if (bit_r == 4'h8) begin
               bit_r    <= 4'h0;
               st_r     <= I_WACK;
               o_sda_oe <= 1'b1;
               first_r  <= 1'b0;
               ptr_r    <= first_r ? sh_r : ptr_r + 8'h01;
            end
            I_WACK: begin
               st_r     <= I_WR;
               o_sda_oe <= 1'b0;
            end
            I_RD: if (bit_r == 4'h8) begin
               bit_r    <= 4'h0;
               st_r     <= I_RACK;
               o_sda_oe <= 1'b0;
            end else begin
               tx_r     <= {tx_r[6:0], 1'b0};
               o_sda_oe <= ~tx_r[6];
            end
            I_RACK: if (!nack_r) begin
               st_r     <= I_RD;
               tx_r     <= rd_val;
               o_sda_oe <= ~rd_val[7];
               ptr_r    <= ptr_r + 8'h01;
            end else begin
               st_r <= I_IDLE;
            end
            default: st_r <= I_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      o_sda_out <= 1'b0;
   end

   // Control registers
   logic [7:0] cfg_r, led_hi_r, led_lo_r, effect_r, chan_cfg_r, gpio_cfg_r;
   logic [7:0] gpio_val_r, irq_en_r, sdiv_r, fdly_r, fstart_r;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         cfg_r      <= RST_CONFIG;
         led_hi_r   <= RST_LED;
         led_lo_r   <= RST_LED;
         effect_r   <= RST_ZERO;
         chan_cfg_r <= RST_ZERO;
         gpio_cfg_r <= RST_ZERO;
         gpio_val_r <= RST_ZERO;
         irq_en_r   <= RST_ZERO;
         sdiv_r     <= RST_ZERO;
         fdly_r     <= RST_ZERO;
         fstart_r   <= RST_ZERO;
      end else if (wr_en) begin
         case (ptr_r)
            A_CONFIG:         cfg_r      <= sh_r;
            A_LED_HI:         led_hi_r   <= sh_r;
            A_LED_LO:         led_lo_r   <= sh_r;
            A_EFFECT:         effect_r   <= sh_r;
            A_CHAN_CFG:       chan_cfg_r <= sh_r;
            A_GPIO_CFG:       gpio_cfg_r <= sh_r;
            A_GPIO_OUT:       gpio_val_r <= sh_r;
            A_IRQ_EN:         irq_en_r   <= sh_r;
            A_SAMPLE_DIV:     sdiv_r     <= sh_r;
            A_FRAME_INTERVAL: fdly_r     <= sh_r & 8'he0;
            A_FIRST_FRAME:    fstart_r   <= sh_r & 8'he0;
            default: ;
         endcase
      end
   end

   // Duty shadow and live copies
   logic [7:0] shadow_r [CHANNELS];
   logic [7:0] live_r   [CHANNELS];
   logic       duty_wr, commit;
   assign duty_wr = wr_en && ptr_r >= A_DUTY_BASE && ptr_r <= A_DUTY_LAST;
   assign commit  = wr_en && ptr_r == A_DUTY_COMMIT && sh_r == COMMIT_KEY;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            shadow_r[i] <= RST_ZERO;
            live_r[i]   <= RST_ZERO;
         end
      end else if (duty_wr) begin
         shadow_r[ptr_r[3:0]] <= sh_r;
      end else if (commit) begin
         live_r <= shadow_r;
      end
   end

   // Input snapshot and interrupt
   logic [UPPER-1:0] is_input, chg;
   assign is_input = chan_cfg_r & gpio_cfg_r;
   assign chg      = (gin_s ^ gin_d) & is_input & ~irq_en_r;

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         snap_r <= RST_ZERO;
      end else begin
         snap_r <= gin_s;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_irq_n_pin <= 1'b1;
      end else if (|chg) begin
         o_irq_n_pin <= 1'b0;
      end else if (rd_snap) begin
         o_irq_n_pin <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_gpio_out  <= '0;
         o_gpio_oe   <= '0;
         o_cur_scale <= 3'h0;
      end else begin
         o_gpio_out  <= gpio_val_r;
         o_gpio_oe   <= chan_cfg_r & ~gpio_cfg_r;
         o_cur_scale <= effect_r[CS_LSB +: 3];
      end
   end

   // Frame source selection
   lfp_mode_t   mode;
   logic [15:0] led_mask;
   assign mode     = lfp_mode_t'(cfg_r[MODE_LSB +: 2]);
   assign led_mask = ~{chan_cfg_r, 8'h00};

   lfp_frame_if frm ();
   lfp_frame_if shw ();

   lfp_frame_player #(
      .FRAME_DLY0_CYC (FRAME_DLY0_CYC),
      .FRAME_DLY1_CYC (FRAME_DLY1_CYC)
   ) u_player (
      .i_clk        (i_clk),
      .i_nrst       (i_nrst),
      .i_wr_en      (wr_en),
      .i_wr_addr    (ptr_r),
      .i_wr_data    (sh_r),
      .i_mode       (mode),
      .i_delay_code (fdly_r[FDT_LSB +: 3]),
      .i_start_code (fstart_r[FS_LSB +: 3]),
      .i_sample_div (sdiv_r),
      .i_level      (lvl_s),
      .frm          (frm)
   );

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         shw.on_mask <= '0;
         for (int i = 0; i < CHANNELS; i++) shw.duty[i] <= RST_ZERO;
      end else if (mode == MODE_AUTO || mode == MODE_AUDIO) begin
         shw.on_mask <= frm.on_mask & led_mask;
         shw.duty    <= frm.duty;
      end else begin
         shw.on_mask <= {led_hi_r, led_lo_r} & led_mask;
         shw.duty    <= live_r;
      end
   end

   lfp_pwm_bank u_pwm (
      .i_clk  (i_clk),
      .i_nrst (i_nrst),
      .shw    (shw),
      .o_pwm  (o_led_pwm)
   );

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   property p_snap_read;
      (load_tx && ptr_r == A_INPUT_SNAP) |=> tx_r == $past(snap_r);
   endproperty
   a_snap_read: assert property (p_snap_read) else $error("Snapshot not returned");

   property p_irq_hold;
      (!o_irq_n_pin && !rd_snap) |=> !o_irq_n_pin;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("Interrupt released early");

   property p_irq_set;
      (|chg) |=> !o_irq_n_pin;
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("Change missed");

   property p_irq_mask;
      (o_irq_n_pin && !(|chg) && |((gin_s ^ gin_d) & is_input & irq_en_r)) |=> o_irq_n_pin;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("Disabled channel interrupted");

   property p_commit;
      commit |=> live_r[0] == $past(shadow_r[0]) && live_r[15] == $past(shadow_r[15]);
   endproperty
   a_commit: assert property (p_commit) else $error("Commit did not load duty");

   property p_shadow_only;
      duty_wr |=> $stable(live_r[0]) && $stable(live_r[9]);
   endproperty
   a_shadow_only: assert property (p_shadow_only) else $error("Duty write bypassed latch");

   property p_live_shown;
      (mode == MODE_PWM) |=> shw.duty[3] == $past(live_r[3]);
   endproperty
   a_live_shown: assert property (p_live_shown) else $error("Live duty not shown");

   property p_scale;
      1'b1 |=> o_cur_scale == $past(effect_r[6:4]);
   endproperty
   a_scale: assert property (p_scale) else $error("Scale field not applied");

   c_commit:  cover property (commit);
   c_irq:     cover property (!o_irq_n_pin ##1 rd_snap ##1 o_irq_n_pin);
   c_wr_data: cover property (wr_en ##[1:300] wr_en);
endmodule

// file: lfp_host_model.sv
// Host master model for the two-wire register bus
`timescale 1ns/100ps
module lfp_host_model #(
   parameter logic [6:0] ADDR = 7'h3a
) (
   // Clock
   input  wire logic i_clk,
   // Bus lines
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_low
);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // One phase of 6 clocks keeps SCL above the 4-clock minimum
   task automatic st(input logic c, input logic d);
      repeat (6) @(posedge i_clk);
      o_scl <= c;
      o_sda_low <= ~d;
   endtask
   // SCL falls first so SDA never moves while SCL is high
   task automatic bt(input logic b);
      st(1'b0, ~o_sda_low);
      st(1'b0, b);
      st(1'b1, b);
   endtask
   task automatic start;
      bt(1'b1);
      st(1'b1, 1'b0);
   endtask
   task automatic stop;
      bt(1'b0);
      st(1'b1, 1'b1);
   endtask
   task automatic tx(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         bt(b[i]);
      end
      bt(1'b1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      tx({ADDR, 1'b0});
      tx(a);
      tx(d);
      stop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      start();
      tx({ADDR, 1'b0});
      tx(a);
      start();
      tx({ADDR, 1'b1});
      for (int i = 7; i >= 0; i--) begin
         bt(1'b1);
         repeat (5) @(posedge i_clk);
         q[i] = i_sda;
      end
      bt(1'b1);
      stop();
   endtask
endmodule

// file: lfp_top_tb_top.sv
// Testbench for the LED frame player core
`timescale 1ns/100ps
module lfp_top_tb_top;
   typedef struct {logic [7:0] a; logic [7:0] d; logic [8:0] e;} lfp_row_t;
   logic        i_clk = 1'b0;
   logic        i_nrst = 1'b0;
   logic [7:0]  gpio_in = 8'h00;
   logic [7:0]  level = 8'h00;
   logic        scl, host_low, sda_oe, irq_n;
   logic [15:0] pwm;
   logic [2:0]  cs;
   logic [8:0]  n;
   logic [7:0]  q;
   logic [7:0]  gout, goe;
   int          err_count = 0;
   int          checked = 0;
   wire         sda = ~(sda_oe | host_low);
   lfp_row_t rows [7] = '{
      '{8'h10, 8'h04, 9'h00}, '{8'hb0, 8'h01, 9'h00},
      '{8'hb0, 8'h00, 9'h04}, '{8'h10, 8'h95, 9'h04},
      '{8'hb0, 8'h00, 9'h95}, '{8'h10, 8'hff, 9'h95},
      '{8'hb0, 8'h00, 9'hff}};
   always #4 i_clk = ~i_clk;
   lfp_top #(.FRAME_DLY0_CYC(600), .FRAME_DLY1_CYC(1200)) u_lfp_top (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda_in(sda),
      .o_sda_out(), .o_sda_oe(sda_oe), .i_gpio_in(gpio_in), .o_gpio_out(gout),
      .o_gpio_oe(goe), .i_audio_level(level), .o_led_pwm(pwm),
      .o_cur_scale(cs), .o_irq_n_pin(irq_n));
   lfp_host_model u_lfp_host_model (
      .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      u_lfp_host_model.wr(a, d);
   endtask
   task automatic chk(input logic [8:0] s, input logic [8:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("mismatch %0t seen %0h exp %0h", $time, s, e);
      end
   endtask
   // On-clock count of channel 0 over one full PWM period
   task automatic cnt(input int pre);
      repeat (pre) @(posedge i_clk);
      n = 9'h000;
      repeat (256) begin
         @(posedge i_clk);
         n = n + 9'(pwm[0]);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge i_clk);
      err_count++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      cnt(4);
      chk(n, 9'h000);
      foreach (rows[i]) begin
         w(rows[i].a, rows[i].d);
         cnt(0);
         chk(n, rows[i].e);
      end
      w(8'h03, 8'h50);
      chk({6'h00, cs}, 9'h005);
      w(8'h04, 8'hff);
      chk({1'b0, goe}, 9'h0ff);
      w(8'h05, 8'hff);
      chk({1'b0, goe}, 9'h000);
      w(8'h06, 8'h5a);
      chk({1'b0, gout}, 9'h05a);
      w(8'h07, 8'hfe);
      @(posedge i_clk) gpio_in <= 8'h02;
      repeat (8) @(posedge i_clk);
      chk({8'h00, irq_n}, 9'h001);
      gpio_in <= 8'h03;
      repeat (8) @(posedge i_clk);
      chk({8'h00, irq_n}, 9'h000);
      w(8'h09, 8'h00);
      chk({8'h00, irq_n}, 9'h000);
      u_lfp_host_model.rd(8'h08, q);
      chk({1'b0, q}, 9'h003);
      chk({8'h00, irq_n}, 9'h001);
      for (int f = 0; f < 8; f++) begin
         w(8'(8'h21 + 18 * f), 8'h01);
         w(8'(8'h22 + 18 * f), 8'(16 * f + 16));
      end
      w(8'hb7, 8'h60);
      w(8'hb6, 8'h00);
      w(8'h00, 8'h20);
      for (int k = 0; k < 7; k++) begin
         cnt(k ? 344 : 20);
         chk(n, 9'(16 * ((k + 3) % 8) + 16));
      end
      @(posedge i_clk) level <= 8'he0;
      w(8'h09, 8'h01);
      w(8'h00, 8'h40);
      cnt(1300);
      chk(n, 9'h080);
      w(8'h09, 8'h00);
      level <= 8'h00;
      cnt(2600);
      chk(n, 9'h080);
      w(8'h09, 8'h02);
      cnt(2600);
      chk(n, 9'h010);
      complete_run();
   end
endmodule
